// file: jlc_pkg.sv
// Shared constants and types for the link configuration register bank.
package jlc_pkg;

  // ********************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************
  localparam logic [9:0] IDX_LINK_ENABLE = 10'h200;
  localparam logic [9:0] IDX_LINK_MODE = 10'h201;
  localparam logic [9:0] IDX_FRAMES_PER_MF = 10'h202;
  localparam logic [9:0] IDX_MANUAL_SYNC = 10'h203;
  localparam logic [9:0] IDX_EFFECTIVE_K = 10'h20e;
  localparam logic [9:0] IDX_STATUS = 10'h20f;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [7:0] RST_LINK_ENABLE = 8'h01;
  localparam logic [7:0] RST_LINK_MODE = 8'h02;
  localparam logic [7:0] RST_FRAMES_PER_MF = 8'h1f;
  localparam logic [7:0] RST_MANUAL_SYNC = 8'h01;
  localparam logic [15:0] RST_EFFECTIVE_K_M1 = 16'h001f;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int BIT_LINK_ENABLE = 0;
  localparam int BIT_MANUAL_SYNC = 0;
  localparam int ST_LINK_ON = 0;
  localparam int ST_CAL_ENABLE = 1;
  localparam int ST_SYNC_REQUEST = 2;
  localparam int ST_FLAG_LO = 3;
  localparam int ST_COUNT_LO = 16;
  localparam int NUM_FLAGS = 3;
  localparam int FLAG_ORDER = 0;
  localparam int FLAG_CONFIG = 1;
  localparam int FLAG_MODE = 2;

  // ********************************************************
  // Mode lock and multiframe scaling
  // ********************************************************
  localparam logic [7:0] LOCKED_MODE_MAX = 8'h0f;
  localparam logic [15:0] K_SCALE = 16'h0100;

  // ********************************************************
  // Bus slave states
  // ********************************************************
  typedef enum logic [1:0] {
    JLC_IDLE = 2'b01,
    JLC_RESP = 2'b10
  } jlc_apb_state_t;

endpackage

// file: jlc_cfg_if.sv
// Carrier between the register bank and its multiframe helpers.
`timescale 1ns/1ps
`default_nettype none
interface jlc_cfg_if;
  logic hold;
  logic is_64b66b;
  logic [7:0] e;
  logic [7:0] f;
  logic [7:0] frames_m1;
  logic [15:0] k_eff_m1;
  logic frame_tick;
  logic sysref;
  logic mf_boundary;
  logic [15:0] mf_count;

  modport ctrl (
    output hold,
    output is_64b66b,
    output e,
    output f,
    output frames_m1,
    output frame_tick,
    output sysref,
    input k_eff_m1,
    input mf_boundary,
    input mf_count
  );

  modport kcalc (
    input is_64b66b,
    input e,
    input f,
    input frames_m1,
    output k_eff_m1
  );

  modport mfc (
    input hold,
    input k_eff_m1,
    input frame_tick,
    input sysref,
    output mf_boundary,
    output mf_count
  );
endinterface
`default_nettype wire

// file: jlc_kcalc.sv
// Effective multiframe length calculation.
`timescale 1ns/1ps
`default_nettype none
module jlc_kcalc (
  input wire logic pclk,
  input wire logic presetn,
  jlc_cfg_if.kcalc cfg
);
  logic [7:0] divisor;
  logic [23:0] scaled;
  logic [23:0] quot;

  // A zero frame size would divide by zero; treat it as one.
  always_comb begin
    divisor = (cfg.f == 8'h00) ? 8'h01 : cfg.f;
    scaled = {16'h0000, cfg.e} * {8'h00, jlc_pkg::K_SCALE};
    quot = scaled / {16'h0000, divisor};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.k_eff_m1 <= jlc_pkg::RST_EFFECTIVE_K_M1;
    end else if (cfg.is_64b66b) begin
      cfg.k_eff_m1 <= (quot[15:0] == 16'h0000) ? 16'h0000 : quot[15:0] - 16'h0001;
    end else begin
      cfg.k_eff_m1 <= {8'h00, cfg.frames_m1};
    end
  end
endmodule
`default_nettype wire

// file: jlc_mfc.sv
// Multiframe counter with realignment.
`timescale 1ns/1ps
`default_nettype none
module jlc_mfc (
  input wire logic pclk,
  input wire logic presetn,
  jlc_cfg_if.mfc cfg
);
  logic wrap;

  // Wrapping on greater-or-equal recovers if K shrinks mid-count.
  assign wrap = cfg.frame_tick && (cfg.mf_count >= cfg.k_eff_m1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.mf_count <= 16'h0000;
    end else if (cfg.hold) begin
      cfg.mf_count <= 16'h0000;
    end else if (cfg.sysref || wrap) begin
      cfg.mf_count <= 16'h0000;
    end else if (cfg.frame_tick) begin
      cfg.mf_count <= cfg.mf_count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.mf_boundary <= 1'b0;
    end else begin
      cfg.mf_boundary <= !cfg.hold && (cfg.sysref || wrap);
    end
  end
endmodule
`default_nettype wire

// file: jlc_regs.sv
// Link configuration register bank with APB slave and subsystem controls.
//
// Functional notes
// - Enable bit 0: 0 disables, 1 enables the transmit interface; resets to 1.
// - Enable low holds the subsystem in reset and powers serializers down.
// - Enable low gates off the subsystem clocks.
// - Enable low holds the multiframe counter in reset; SYSREF cannot realign it.
// - Eight-bit mode register selects operating mode; resets to 2.
// - A mode lock setting decides which mode values are accepted.
// - Eight-bit register holds K minus one; resets to 31, meaning K of 32.
// - In 64b/66b modes K comes from 256 times E over F instead.
// - Manual sync register resets to 0x01, no request asserted.
// - Bit 0 low requests synchronization like the sync pin; keep high normally.
`timescale 1ns/1ps
`default_nettype none
module jlc_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cal_enable,
  input wire logic mode_lock,
  input wire logic sync_pin_low,
  input wire logic mode_is_64b66b,
  input wire logic [7:0] mode_e,
  input wire logic [7:0] mode_f,
  input wire logic frame_tick,
  input wire logic sysref,
  output logic subsys_reset_low,
  output logic serializer_power_down,
  output logic subsys_clock_enable,
  output logic multiframe_counter_hold,
  output logic sync_request,
  output logic [7:0] link_mode,
  output logic mf_boundary
);

  // ********************************************************
  // Declarations
  // ********************************************************
  jlc_pkg::jlc_apb_state_t state;
  jlc_pkg::jlc_apb_state_t next_state;

  logic [7:0] link_enable;
  logic [7:0] link_mode_select;
  logic [7:0] frames_per_multiframe_minus_one;
  logic [7:0] manual_sync_request;
  logic [jlc_pkg::NUM_FLAGS-1:0] flags;
  logic [jlc_pkg::NUM_FLAGS-1:0] flag_set;
  logic [jlc_pkg::NUM_FLAGS-1:0] flag_clear;

  logic [9:0] word_index;
  logic addr_hit;
  logic xfer_done;
  logic wr_lane0;
  logic wr_link_enable;
  logic wr_link_mode;
  logic wr_frames;
  logic wr_manual_sync;
  logic wr_status;
  logic mode_allowed;
  logic link_on;
  logic cal_prev;
  logic manual_sync_low;
  logic [31:0] next_prdata;
  logic [31:0] status_word;

  jlc_cfg_if cfg ();

  // ********************************************************
  // Address decode
  // ********************************************************
  assign word_index = paddr[11:2];
  assign xfer_done = psel && penable && pready;
  // Only byte lane 0 carries register data; a write without it is dropped quietly.
  assign wr_lane0 = xfer_done && pwrite && pstrb[0];
  assign wr_link_enable = wr_lane0 && (word_index == jlc_pkg::IDX_LINK_ENABLE);
  assign wr_link_mode = wr_lane0 && (word_index == jlc_pkg::IDX_LINK_MODE);
  assign wr_frames = wr_lane0 && (word_index == jlc_pkg::IDX_FRAMES_PER_MF);
  assign wr_manual_sync = wr_lane0 && (word_index == jlc_pkg::IDX_MANUAL_SYNC);
  assign wr_status = wr_lane0 && (word_index == jlc_pkg::IDX_STATUS);

  // Unmapped indices answer with an error and have no side effect.
  always_comb begin
    case (word_index)
      jlc_pkg::IDX_LINK_ENABLE,
      jlc_pkg::IDX_LINK_MODE,
      jlc_pkg::IDX_FRAMES_PER_MF,
      jlc_pkg::IDX_MANUAL_SYNC,
      jlc_pkg::IDX_EFFECTIVE_K,
      jlc_pkg::IDX_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // ********************************************************
  // APB slave sequencing
  // ********************************************************
  // One wait state lets read data and the error answer come from flops.
  always_comb begin
    case (state)
      jlc_pkg::JLC_IDLE: begin
        next_state = (psel && penable) ? jlc_pkg::JLC_RESP : jlc_pkg::JLC_IDLE;
      end
      jlc_pkg::JLC_RESP: begin
        next_state = jlc_pkg::JLC_IDLE;
      end
      default: begin
        next_state = jlc_pkg::JLC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= jlc_pkg::JLC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if ((state == jlc_pkg::JLC_IDLE) && psel && penable) begin
      pready <= 1'b1;
      pslverr <= !addr_hit;
      prdata <= (pwrite || !addr_hit) ? 32'h0000_0000 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // ********************************************************
  // Read data
  // ********************************************************
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[jlc_pkg::ST_LINK_ON] = link_on;
    status_word[jlc_pkg::ST_CAL_ENABLE] = cal_enable;
    status_word[jlc_pkg::ST_SYNC_REQUEST] = sync_request;
    status_word[jlc_pkg::ST_FLAG_LO +: jlc_pkg::NUM_FLAGS] = flags;
    status_word[jlc_pkg::ST_COUNT_LO +: 16] = cfg.mf_count;
  end

  always_comb begin
    case (word_index)
      jlc_pkg::IDX_LINK_ENABLE: next_prdata = {24'h000000, link_enable};
      jlc_pkg::IDX_LINK_MODE: next_prdata = {24'h000000, link_mode_select};
      jlc_pkg::IDX_FRAMES_PER_MF: next_prdata = {24'h000000, frames_per_multiframe_minus_one};
      jlc_pkg::IDX_MANUAL_SYNC: next_prdata = {24'h000000, manual_sync_request};
      jlc_pkg::IDX_EFFECTIVE_K: next_prdata = {16'h0000, cfg.k_eff_m1};
      jlc_pkg::IDX_STATUS: next_prdata = status_word;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // ********************************************************
  // Configuration registers
  // ********************************************************
  // Reserved bits are stored and read back; only bit 0 acts.
  // enable bit, resets to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_enable <= jlc_pkg::RST_LINK_ENABLE;
    end else if (wr_link_enable) begin
      link_enable <= pwdata[7:0];
    end
  end

  assign link_on = link_enable[jlc_pkg::BIT_LINK_ENABLE];

  // A refused mode write leaves the register as it was and raises the mode flag.
  // mode lock filter
  assign mode_allowed = !mode_lock || (pwdata[7:0] <= jlc_pkg::LOCKED_MODE_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_mode_select <= jlc_pkg::RST_LINK_MODE;
    end else if (wr_link_mode && mode_allowed) begin
      link_mode_select <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frames_per_multiframe_minus_one <= jlc_pkg::RST_FRAMES_PER_MF;
    end else if (wr_frames) begin
      frames_per_multiframe_minus_one <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_sync_request <= jlc_pkg::RST_MANUAL_SYNC;
    end else if (wr_manual_sync) begin
      manual_sync_request <= pwdata[7:0];
    end
  end

  // Bit 0 is active low: zero asks for synchronization.
  assign manual_sync_low = manual_sync_request[jlc_pkg::BIT_MANUAL_SYNC];

  // ********************************************************
  // Sequence error flags
  // ********************************************************
  // Previous calibration enable, to spot it falling while the link is on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_prev <= 1'b0;
    end else begin
      cal_prev <= cal_enable;
    end
  end

  assign flag_set[jlc_pkg::FLAG_ORDER] =
    (wr_link_enable && pwdata[jlc_pkg::BIT_LINK_ENABLE] && !link_on && !cal_enable) ||
    (cal_prev && !cal_enable && link_on);
  // mode change needs both enables low
  assign flag_set[jlc_pkg::FLAG_CONFIG] =
    (wr_link_mode && (link_on || cal_enable)) || (wr_frames && link_on);
  assign flag_set[jlc_pkg::FLAG_MODE] = wr_link_mode && !mode_allowed;

  // Flags are sticky; software clears one by writing a one to its status bit.
  assign flag_clear = wr_status ? pwdata[jlc_pkg::ST_FLAG_LO +: jlc_pkg::NUM_FLAGS] : '0;

  // A new event in the clearing cycle keeps its flag.
  for (genvar i = 0; i < jlc_pkg::NUM_FLAGS; i++) begin : g_flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flags[i] <= 1'b0;
      end else if (flag_set[i]) begin
        flags[i] <= 1'b1;
      end else if (flag_clear[i]) begin
        flags[i] <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Subsystem controls
  // ********************************************************
  // The reset, power-down, clock and counter-hold controls follow the enable one cycle late. All of them move on the
  // same edge, so the subsystem always sees one coherent change of state.
  // reset and serializer power down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subsys_reset_low <= 1'b1;
      serializer_power_down <= 1'b0;
    end else begin
      subsys_reset_low <= link_on;
      serializer_power_down <= !link_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subsys_clock_enable <= 1'b1;
    end else begin
      subsys_clock_enable <= link_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multiframe_counter_hold <= 1'b0;
    end else begin
      multiframe_counter_hold <= !link_on;
    end
  end

  // The register bit and the pin are merged; either one low requests sync.
  // manual request acts like the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_request <= 1'b0;
    end else begin
      sync_request <= !manual_sync_low || !sync_pin_low;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_mode <= jlc_pkg::RST_LINK_MODE;
    end else begin
      link_mode <= link_mode_select;
    end
  end

  assign mf_boundary = cfg.mf_boundary;

  // ********************************************************
  // Multiframe helpers
  // ********************************************************
  // counter held and ticks gated
  assign cfg.hold = !link_on;
  assign cfg.frame_tick = frame_tick && link_on;
  assign cfg.sysref = sysref && link_on;
  assign cfg.is_64b66b = mode_is_64b66b;
  assign cfg.e = mode_e;
  assign cfg.f = mode_f;
  assign cfg.frames_m1 = frames_per_multiframe_minus_one;

  jlc_kcalc u_kcalc (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg.kcalc)
  );

  jlc_mfc u_mfc (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg.mfc)
  );

endmodule
`default_nettype wire

// file: jlc_regs_assertions.sv
// Concurrent checks on the ports of the link configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module jlc_regs_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sync_pin_low,
  input wire logic subsys_reset_low,
  input wire logic serializer_power_down,
  input wire logic subsys_clock_enable,
  input wire logic multiframe_counter_hold,
  input wire logic sync_request,
  input wire logic [7:0] link_mode,
  input wire logic mf_boundary
);
  // ****
  // Completed writes and bus phases
  // ****
  logic done_wr;
  assign done_wr = psel && penable && pready && pwrite && pstrb[0];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_wait;
    psel && penable && !pready;
  endsequence

  chk_apb_one_wait: assert property (s_setup ##1 s_wait |=> pready)
    else $error("ready missing after the single wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside a response");
  chk_ctrl_agree: assert property (subsys_reset_low == subsys_clock_enable &&
    serializer_power_down == !subsys_reset_low && multiframe_counter_hold == serializer_power_down)
    else $error("subsystem controls disagree");
  chk_enable_write: assert property (done_wr && paddr[11:2] == 10'h200 |->
    ##2 subsys_reset_low == $past(pwdata[0], 2))
    else $error("enable write did not reach the controls");
  chk_hold_quiet: assert property (multiframe_counter_hold && $past(multiframe_counter_hold)
    |-> !mf_boundary)
    else $error("boundary while the counter is held");
  chk_pin_sync: assert property (!sync_pin_low |=> sync_request)
    else $error("sync pin did not raise the request");
  chk_mode_cause: assert property ($changed(link_mode) |->
    $past(done_wr && paddr[11:2] == 10'h201, 2))
    else $error("mode output changed without a mode write");
endmodule

bind jlc_regs jlc_regs_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .sync_pin_low, .subsys_reset_low, .serializer_power_down,
  .subsys_clock_enable, .multiframe_counter_hold, .sync_request, .link_mode, .mf_boundary);
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the link configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic cal_enable = 1'b1, mode_lock = 1'b0, sync_pin_low = 1'b1, mode_is_64b66b = 1'b0;
  logic [7:0] mode_e = 8'h01, mode_f = 8'h02;
  logic frame_tick = 1'b0, sysref = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, subsys_reset_low, serializer_power_down, subsys_clock_enable;
  logic multiframe_counter_hold, sync_request, mf_boundary;
  logic [7:0] link_mode;
  int fail_count = 0;
  int checks_done = 0;

  jlc_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .cal_enable, .mode_lock, .sync_pin_low, .mode_is_64b66b, .mode_e, .mode_f, .frame_tick,
    .sysref, .subsys_reset_low, .serializer_power_down, .subsys_clock_enable, .multiframe_counter_hold,
    .sync_request, .link_mode, .mf_boundary);

  always #10 pclk = ~pclk;

  // ****
  // Shared tasks
  // ****
  task automatic stop_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // The request stays put until ready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (pready !== 1'b1) begin
      fail_count++;
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    cmp(rd, exp);
  endtask

  task automatic pulse(input logic s, output logic seen);
    sysref <= s;
    frame_tick <= !s;
    @(posedge pclk);
    sysref <= 1'b0;
    frame_tick <= 1'b0;
    seen = 1'b0;
    repeat (2) begin
      @(posedge pclk);
      seen = seen | mf_boundary;
    end
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset_values();
    rdchk(12'h800, 32'h01);
    rdchk(12'h804, 32'h02);
    rdchk(12'h808, 32'h1f);
    rdchk(12'h80c, 32'h01);
    rdchk(12'h838, 32'h1f);
    cmp({24'h0, link_mode}, 32'h02);
    cmp_bit(sync_request, 1'b0);
  endtask

  task automatic t_disable();
    logic seen;
    wr(12'h800, 32'h0);
    tick(2);
    cmp_bit(subsys_reset_low, 1'b0);
    cmp_bit(serializer_power_down, 1'b1);
    cmp_bit(subsys_clock_enable, 1'b0);
    cmp_bit(multiframe_counter_hold, 1'b1);
    pulse(1'b1, seen);
    cmp_bit(seen, 1'b0);
    pulse(1'b0, seen);
    cmp_bit(seen, 1'b0);
    // A write with the low byte strobe off must leave the bit alone.
    pstrb <= 4'h0;
    wr(12'h800, 32'h1);
    pstrb <= 4'hf;
    rdchk(12'h800, 32'h0);
  endtask

  task automatic t_mode();
    cal_enable <= 1'b0;
    mode_lock <= 1'b1;
    wr(12'h804, 32'h10);
    rdchk(12'h804, 32'h02);
    wr(12'h804, 32'h0f);
    rdchk(12'h804, 32'h0f);
    mode_lock <= 1'b0;
    wr(12'h804, 32'h10);
    rdchk(12'h804, 32'h10);
    cmp({24'h0, link_mode}, 32'h10);
    rdchk(12'h83c, 32'h20);
    wr(12'h83c, 32'h20);
    rdchk(12'h83c, 32'h0);
  endtask

  task automatic t_klen();
    wr(12'h808, 32'h03);
    rdchk(12'h838, 32'h03);
    wr(12'h838, 32'h55);
    rdchk(12'h838, 32'h03);
    mode_is_64b66b <= 1'b1;
    tick(2);
    rdchk(12'h838, 32'h7f);
    mode_e <= 8'h02;
    mode_f <= 8'h01;
    tick(2);
    rdchk(12'h838, 32'h1ff);
    mode_is_64b66b <= 1'b0;
  endtask

  task automatic t_sync();
    wr(12'h80c, 32'h0);
    tick(2);
    cmp_bit(sync_request, 1'b1);
    wr(12'h80c, 32'h1);
    tick(2);
    cmp_bit(sync_request, 1'b0);
    sync_pin_low <= 1'b0;
    tick(2);
    cmp_bit(sync_request, 1'b1);
    sync_pin_low <= 1'b1;
    tick(2);
  endtask

  task automatic t_enable_count();
    logic seen;
    logic [31:0] rd;
    logic err;
    cal_enable <= 1'b1;
    wr(12'h800, 32'h1);
    tick(2);
    cmp_bit(subsys_clock_enable, 1'b1);
    pulse(1'b1, seen);
    cmp_bit(seen, 1'b1);
    // With K of four the fourth frame after realignment closes the multiframe.
    for (int i = 0; i < 4; i++) begin
      pulse(1'b0, seen);
      cmp_bit(seen, i == 3);
    end
    apb(1'b0, 12'h900, 32'h0, rd, err);
    cmp(rd, 32'h0);
    cmp_bit(err, 1'b1);
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_disable();
    t_mode();
    t_klen();
    t_sync();
    t_enable_count();
    stop_test();
  end
endmodule
`default_nettype wire
